// ### design/agccs_pkg.sv
//------------------------------------------------------------------------------
// Purpose : constants, decoders and state type for the gain control and
//           carrier sense block
// Assumes : all levels are in whole dB, carried as 10-bit unsigned values
// Notes   : register map, field positions and reset values live here only
//------------------------------------------------------------------------------
package agccs_pkg;

    //--------------------------------------------------------------------------
    // register map
    //--------------------------------------------------------------------------
    localparam int         ADDR_W          = 6;
    localparam int         DATA_W          = 8;
    localparam int         DB_W            = 10;
    localparam logic [5:0] ADDR_THRESHOLDS = 6'h1C;  // gain_control_thresholds
    localparam logic [5:0] ADDR_TIMING     = 6'h1D;  // gain_control_loop_timing
    localparam logic [7:0] RST_THRESHOLDS  = 8'h40;  // priority 1, rel 00, abs 0000
    localparam logic [7:0] RST_TIMING      = 8'h91;  // dead zone 10, wait 01, low nibble 0001
    localparam logic [7:0] THRESH_WR_MASK  = 8'h7F;  // top bit is not used

    //--------------------------------------------------------------------------
    // field positions and special codes
    //--------------------------------------------------------------------------
    localparam int         PRIO_BIT  = 6;
    localparam int         REL_LSB   = 4;
    localparam int         ABS_LSB   = 0;
    localparam int         DZ_LSB    = 6;
    localparam int         WAIT_LSB  = 4;
    localparam logic [1:0] REL_OFF   = 2'h0;
    localparam logic [3:0] ABS_OFF   = 4'h8;         // minus eight means disabled

    //--------------------------------------------------------------------------
    // gain stages
    //--------------------------------------------------------------------------
    localparam int         STAGE_W   = 3;
    localparam logic [2:0] STAGE_MAX = 3'h7;         // full gain of one stage
    localparam logic [2:0] STAGE_MIN = 3'h0;
    localparam logic [5:0] WAIT_UNIT = 6'h08;        // settle wait grows in steps of 8

    typedef enum logic [0:0] {AGCCS_SETTLE, AGCCS_TRACK} agccs_state_t;

    // amplitude goal in dB for each code
    function automatic logic [9:0] agccs_goal_db(input logic [2:0] code);
        case (code)
            3'h0:    agccs_goal_db = 10'h018;  // 24
            3'h1:    agccs_goal_db = 10'h01B;  // 27
            3'h2:    agccs_goal_db = 10'h01E;  // 30
            3'h3:    agccs_goal_db = 10'h021;  // 33
            3'h4:    agccs_goal_db = 10'h024;  // 36
            3'h5:    agccs_goal_db = 10'h026;  // 38
            3'h6:    agccs_goal_db = 10'h028;  // 40
            default: agccs_goal_db = 10'h02A;  // 42
        endcase
    endfunction : agccs_goal_db

    // relative rise needed for carrier sense, 0 when disabled
    function automatic logic [9:0] agccs_rel_db(input logic [1:0] code);
        case (code)
            2'h1:    agccs_rel_db = 10'h006;
            2'h2:    agccs_rel_db = 10'h00A;
            2'h3:    agccs_rel_db = 10'h00E;
            default: agccs_rel_db = 10'h000;
        endcase
    endfunction : agccs_rel_db

    // samples to ignore after a gain step: 8, 16, 24, 32
    function automatic logic [5:0] agccs_wait(input logic [1:0] code);
        agccs_wait = WAIT_UNIT * ({4'h0, code} + 6'h01);
    endfunction : agccs_wait

    // dead zone above the goal before gain is lowered
    function automatic logic [9:0] agccs_zone_hi(input logic [1:0] code);
        case (code)
            2'h0:    agccs_zone_hi = 10'h001;
            2'h1:    agccs_zone_hi = 10'h002;
            2'h2:    agccs_zone_hi = 10'h004;
            default: agccs_zone_hi = 10'h008;
        endcase
    endfunction : agccs_zone_hi

    // dead zone below the goal before gain is raised
    function automatic logic [9:0] agccs_zone_lo(input logic [1:0] code);
        case (code)
            2'h0:    agccs_zone_lo = 10'h001;
            2'h1:    agccs_zone_lo = 10'h001;
            2'h2:    agccs_zone_lo = 10'h002;
            default: agccs_zone_lo = 10'h004;
        endcase
    endfunction : agccs_zone_lo

endpackage : agccs_pkg

// ### design/agccs_core.sv
//------------------------------------------------------------------------------
// Purpose : gain stepping between two front-end stages and carrier sense
// Assumes : amplitude samples arrive on clk_i with a one-cycle valid strobe
// Notes   : registers reached by a plain address/strobe port
//
// Behaviour
// - with the priority bit set, gain is lowered on the first stage before the second.
// - with the priority bit clear, the second stage goes to minimum before the first is lowered.
// - carrier sense asserts on a sudden rise of signal strength by the selected relative step.
// - relative code 00 disables, 01 needs 6 dB, 10 needs 10 dB, 11 needs 14 dB.
// - carrier sense asserts when strength passes the goal plus a signed 1 dB step offset.
// - absolute code 1000 disables absolute detection instead of meaning eight below.
// - codes 1001 to 0111 place the level from 7 dB below to 7 dB above the goal.
// - the absolute level is compared with the amplitude as it would be without gain reduction.
// - the dead zone code picks 1, 2, 4 or 8 dB above and 1, 1, 2 or 4 dB below the goal as hysteresis on gain changes.
// - after a gain step, 8, 16, 24 or 32 samples are ignored before tracking resumes.
// - the top bit of the thresholds register reads zero and ignores writes.
// - the amplitude goal spans 24 to 42 dB over eight codes, defaulting to 33 dB.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module agccs_core
    import agccs_pkg::*;
#(
    parameter int          AMP_W   = 8,            // width of the amplitude estimate
    parameter logic [9:0]  STEP_DB = 10'h003,      // gain lost per stage step
    parameter logic [2:0]  GOAL    = 3'h3          // amplitude goal code
) (
    input  wire logic              clk_i,          // 50 MHz clock
    input  wire logic              reset_i,        // sync reset, active high
    input  wire logic [ADDR_W-1:0] reg_addr_i,     // register address
    input  wire logic [7:0]        reg_wdata_i,    // write data
    input  wire logic              reg_wr_i,       // write strobe
    input  wire logic              reg_rd_i,       // read strobe
    output logic      [7:0]        reg_rdata_o,    // read data, one cycle later
    input  wire logic              sample_valid_i, // new amplitude sample
    input  wire logic [AMP_W-1:0]  amplitude_i,    // amplitude in dB after gain
    output logic      [2:0]        stage1_gain_o,  // first amplifier stage gain
    output logic      [2:0]        stage2_gain_o,  // second amplifier stage gain
    output logic                   gain_step_o,    // pulse on each gain change
    output logic                   carrier_sense_o // carrier sense level
);

    //--------------------------------------------------------------------------
    // registers
    //--------------------------------------------------------------------------
    logic [7:0]   thresholds_ff;
    logic [7:0]   timing_ff;
    logic [2:0]   lna1_ff;
    logic [2:0]   lna2_ff;
    logic [5:0]   settle_cnt_ff;
    agccs_state_t state_ff;
    logic         step_ff;
    logic         cs_ff;
    logic         rel_hold_ff;
    logic [9:0]   rel_base_ff;
    logic [9:0]   prev_lvl_ff;
    logic         have_prev_ff;
    logic [7:0]   rdata_ff;

    //--------------------------------------------------------------------------
    // decoded fields and levels
    //--------------------------------------------------------------------------
    logic       amp_stage_priority;
    logic [1:0] cs_relative_step;
    logic [3:0] cs_absolute_level;
    logic [1:0] gain_dead_zone_select;
    logic [1:0] settle_code;
    logic [9:0] amplitude_goal_db;
    logic [9:0] rel_db;
    logic [9:0] reduction_db;
    logic [9:0] raw_lvl;
    logic [9:0] abs_lvl;
    logic       abs_en;
    logic       rel_en;
    logic       abs_hit;
    logic       rel_hit;
    logic       too_high;
    logic       too_low;
    logic       can_lower;
    logic       can_raise;
    logic       track_sample;
    logic       dec_req;
    logic       inc_req;

    assign amp_stage_priority    = thresholds_ff[PRIO_BIT];
    assign cs_relative_step      = thresholds_ff[REL_LSB +: 2];
    assign cs_absolute_level     = thresholds_ff[ABS_LSB +: 4];
    assign gain_dead_zone_select = timing_ff[DZ_LSB +: 2];
    assign settle_code           = timing_ff[WAIT_LSB +: 2];
    assign amplitude_goal_db     = agccs_goal_db(GOAL);
    assign rel_db                = agccs_rel_db(cs_relative_step);

    // gain taken away by both stages together
    assign reduction_db = ({7'h00, STAGE_MAX - lna1_ff} + {7'h00, STAGE_MAX - lna2_ff}) * STEP_DB;
    // strength as it would read with no gain reduction
    assign raw_lvl      = DB_W'(amplitude_i) + reduction_db;
    // signed offset in 1 dB steps around the goal; goal is never below 24
    assign abs_lvl      = amplitude_goal_db + {{6{cs_absolute_level[3]}}, cs_absolute_level};
    assign abs_en       = (cs_absolute_level != ABS_OFF);
    assign rel_en       = (cs_relative_step != REL_OFF);
    assign abs_hit      = abs_en && (raw_lvl >= abs_lvl);
    assign rel_hit      = rel_en && have_prev_ff && (raw_lvl >= prev_lvl_ff + rel_db);

    // dead zone keeps the loop from hunting around the goal
    assign too_high     = amplitude_i > AMP_W'(amplitude_goal_db + agccs_zone_hi(gain_dead_zone_select));
    assign too_low      = DB_W'(amplitude_i) + agccs_zone_lo(gain_dead_zone_select) < amplitude_goal_db;
    assign can_lower    = (lna1_ff != STAGE_MIN) || (lna2_ff != STAGE_MIN);
    assign can_raise    = (lna1_ff != STAGE_MAX) || (lna2_ff != STAGE_MAX);
    assign track_sample = sample_valid_i && (state_ff == AGCCS_TRACK);
    assign dec_req      = track_sample && too_high && can_lower;
    assign inc_req      = track_sample && too_low && can_raise;

    //--------------------------------------------------------------------------
    // register writes
    //--------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            thresholds_ff <= RST_THRESHOLDS;
            timing_ff     <= RST_TIMING;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ADDR_THRESHOLDS) begin
                thresholds_ff <= reg_wdata_i & THRESH_WR_MASK;
            end
            if (reg_addr_i == ADDR_TIMING) begin
                timing_ff <= reg_wdata_i;
            end
        end
    end

    // read data; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_THRESHOLDS: rdata_ff <= thresholds_ff & THRESH_WR_MASK;
                ADDR_TIMING:     rdata_ff <= timing_ff;
                default:         rdata_ff <= 8'h00;
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // gain stepping: lowering order follows priority, raising undoes it
    //--------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lna1_ff <= STAGE_MAX;
            lna2_ff <= STAGE_MAX;
        end else if (dec_req) begin
            if (amp_stage_priority) begin
                if (lna1_ff != STAGE_MIN) begin
                    lna1_ff <= lna1_ff - 3'h1;
                end else begin
                    lna2_ff <= lna2_ff - 3'h1;
                end
            end else begin
                if (lna2_ff != STAGE_MIN) begin
                    lna2_ff <= lna2_ff - 3'h1;
                end else begin
                    lna1_ff <= lna1_ff - 3'h1;
                end
            end
        end else if (inc_req) begin
            if (amp_stage_priority) begin
                if (lna2_ff != STAGE_MAX) begin
                    lna2_ff <= lna2_ff + 3'h1;
                end else begin
                    lna1_ff <= lna1_ff + 3'h1;
                end
            end else begin
                if (lna1_ff != STAGE_MAX) begin
                    lna1_ff <= lna1_ff + 3'h1;
                end else begin
                    lna2_ff <= lna2_ff + 3'h1;
                end
            end
        end
    end

    //--------------------------------------------------------------------------
    // settle wait: samples after a step still carry the old gain's transient
    //--------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff      <= AGCCS_TRACK;
            settle_cnt_ff <= 6'h00;
        end else begin
            case (state_ff)
                AGCCS_TRACK: begin
                    if (dec_req || inc_req) begin
                        state_ff      <= AGCCS_SETTLE;
                        settle_cnt_ff <= agccs_wait(settle_code);
                    end
                end
                AGCCS_SETTLE: begin
                    if (sample_valid_i) begin
                        settle_cnt_ff <= settle_cnt_ff - 6'h01;
                        if (settle_cnt_ff == 6'h01) begin
                            state_ff <= AGCCS_TRACK;
                        end
                    end
                end
                default: begin
                    state_ff <= AGCCS_TRACK;
                end
            endcase
        end
    end

    // one-cycle pulse per gain change
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            step_ff <= 1'b0;
        end else begin
            step_ff <= dec_req || inc_req;
        end
    end

    //--------------------------------------------------------------------------
    // carrier sense
    //--------------------------------------------------------------------------
    // previous raw level is the reference for a sudden rise
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prev_lvl_ff  <= 10'h000;
            have_prev_ff <= 1'b0;
        end else if (sample_valid_i) begin
            prev_lvl_ff  <= raw_lvl;
            have_prev_ff <= 1'b1;
        end
    end

    // relative detection holds until strength falls back under base plus step;
    // a new rise in the same cycle wins over the release
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rel_hold_ff <= 1'b0;
            rel_base_ff <= 10'h000;
        end else if (!rel_en) begin
            rel_hold_ff <= 1'b0;
        end else if (sample_valid_i) begin
            if (rel_hit) begin
                rel_hold_ff <= 1'b1;
                rel_base_ff <= prev_lvl_ff;
            end else if (raw_lvl < rel_base_ff + rel_db) begin
                rel_hold_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_ff <= 1'b0;
        end else if (!abs_en && !rel_en) begin
            cs_ff <= 1'b0;
        end else if (sample_valid_i) begin
            cs_ff <= abs_hit || rel_hit || (rel_hold_ff && rel_en && raw_lvl >= rel_base_ff + rel_db);
        end
    end

    assign reg_rdata_o     = rdata_ff;
    assign stage1_gain_o   = lna1_ff;
    assign stage2_gain_o   = lna2_ff;
    assign gain_step_o     = step_ff;
    assign carrier_sense_o = cs_ff;

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_TOP_BIT_ZERO: assert property (reg_rd_i && reg_addr_i == ADDR_THRESHOLDS |=> !reg_rdata_o[7])
        else $error("unused top bit read back as one");
    AST_PRIO_FIRST: assert property (dec_req && amp_stage_priority && lna1_ff != STAGE_MIN
        |=> stage1_gain_o == $past(lna1_ff) - 3'h1 && $stable(stage2_gain_o))
        else $error("first stage not lowered first");
    AST_PRIO_SECOND: assert property (dec_req && !amp_stage_priority && lna2_ff != STAGE_MIN
        |=> stage2_gain_o == $past(lna2_ff) - 3'h1 && $stable(stage1_gain_o))
        else $error("second stage not lowered to minimum first");
    AST_SETTLE_HOLD: assert property (state_ff == AGCCS_SETTLE |=> $stable(stage1_gain_o) && $stable(stage2_gain_o))
        else $error("gain changed during settle wait");
    // the wait was loaded one edge earlier, so a write to the code in between must not matter
    AST_SETTLE_LOAD: assert property (gain_step_o |-> settle_cnt_ff == agccs_wait($past(settle_code)) && state_ff == AGCCS_SETTLE)
        else $error("settle wait not loaded from code");
    AST_ABS_ASSERT: assert property (sample_valid_i && abs_hit |=> carrier_sense_o)
        else $error("absolute level crossed without carrier sense");
    AST_ABS_OFF: assert property (sample_valid_i && cs_absolute_level == ABS_OFF && !rel_en |=> !carrier_sense_o)
        else $error("disabled absolute detection raised carrier sense");
    AST_REL_RISE: assert property (sample_valid_i && rel_hit |=> carrier_sense_o)
        else $error("relative rise missed");
    AST_BOTH_OFF: assert property ((!abs_en && !rel_en) [*2] |-> !carrier_sense_o)
        else $error("carrier sense high with detection disabled");
    AST_STEP_PULSE: assert property (gain_step_o |=> !gain_step_o)
        else $error("gain step pulse longer than one cycle");

    COV_DEC_SECOND: cover property (dec_req && !amp_stage_priority);
    COV_SETTLE_DONE: cover property (state_ff == AGCCS_SETTLE ##1 state_ff == AGCCS_TRACK);
    COV_REL_CS: cover property (sample_valid_i && rel_hit && !abs_hit);
    COV_ABS_CS: cover property (sample_valid_i && abs_hit);

endmodule : agccs_core

`default_nettype wire

// ### sim/agccs_frontend_model.sv
// Purpose : front end model, turns an rf level into the gain-reduced amplitude
// Assumes : whole dB, STEP_DB lost per stage step below full gain
// Notes   : amplitude is scrambled whenever no sample is offered
`timescale 1ns/1ps
`default_nettype none

module agccs_frontend_model #(
    parameter int STEP_DB = 3               // dB lost per stage step
) (
    input  wire logic [2:0] stage1_gain_i,  // first stage gain
    input  wire logic [2:0] stage2_gain_i,  // second stage gain
    input  wire logic [7:0] rf_db_i,        // level at the antenna
    input  wire logic       fire_i,         // offer a sample
    output logic            sample_valid_o, // sample strobe
    output logic      [7:0] amplitude_o     // gain-reduced amplitude
);
    //--------------------------------------------------------------------------
    // amplitude path
    //--------------------------------------------------------------------------
    int red;
    int amp;

    // live gains are used, so back-to-back samples see the newest setting
    always_comb begin
        red = ((7 - int'(stage1_gain_i)) + (7 - int'(stage2_gain_i))) * STEP_DB;
        amp = (int'(rf_db_i) > red) ? int'(rf_db_i) - red : 0;
        sample_valid_o = fire_i;
        // between samples the line shows the inverse, never a stale match
        amplitude_o = fire_i ? amp[7:0] : ~amp[7:0];
    end
endmodule : agccs_frontend_model

`default_nettype wire

// ### sim/test_agccs_core.sv
// Purpose : register and sample path tests of the gain control block
// Assumes : goal code 3 (33 dB), 3 dB per stage step
// Notes   : samples are offered every second cycle through the front end model
`timescale 1ns/1ps
`default_nettype none

module test_agccs_core;
    import agccs_pkg::*;
    logic       clk_i;
    logic       reset_i;
    logic       reg_wr_i;
    logic       reg_rd_i;
    logic       fire;
    logic       valid;
    logic       cs;
    logic       step;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] rf;
    logic [7:0] amp;
    logic [7:0] v;
    logic [2:0] g1;
    logic [2:0] g2;
    int         err_total;
    int         n_tests;
    int         z;
    int         t;

    agccs_core u_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .sample_valid_i(valid),
        .amplitude_i(amp), .stage1_gain_o(g1), .stage2_gain_o(g2), .gain_step_o(step),
        .carrier_sense_o(cs));
    agccs_frontend_model u_fe (.stage1_gain_i(g1), .stage2_gain_i(g2), .rf_db_i(rf), .fire_i(fire),
        .sample_valid_o(valid), .amplitude_o(amp));

    //--------------------------------------------------------------------------
    // clock, watchdog and shared tasks
    //--------------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // the whole run needs about 800 cycles, so 20000 means a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        stop_test();
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick

    task automatic rst(input int n);
        tick();
        reset_i = 1'b1;
        repeat (n) tick();
        reset_i = 1'b0;
    endtask : rst

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        tick();
        addr = a;
        wdata = d;
        reg_wr_i = 1'b1;
        tick();
        reg_wr_i = 1'b0;
    endtask : wr

    // read data is taken just after the edge that samples the strobe
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        tick();
        addr = a;
        reg_rd_i = 1'b1;
        tick();
        reg_rd_i = 1'b0;
        d = rdata;
    endtask : rd

    task automatic smp(input logic [7:0] lvl);
        tick();
        rf = lvl;
        fire = 1'b1;
        tick();
        fire = 1'b0;
    endtask : smp

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    //--------------------------------------------------------------------------
    // test sequence
    //--------------------------------------------------------------------------
    initial begin
        {reset_i, reg_wr_i, reg_rd_i, fire, addr, wdata, rf, err_total, n_tests} = '0;
        reset_i = 1'b1;
        rst(19);
        // register defaults, read-only top bit, unmapped address
        rd(ADDR_THRESHOLDS, v);
        check(v, 8'h40);
        rd(ADDR_TIMING, v);
        check(v, 8'h91);
        wr(ADDR_THRESHOLDS, 8'hFF);
        rd(ADDR_THRESHOLDS, v);
        check(v, 8'h7F);
        wr(6'h1E, 8'h55);
        rd(6'h1E, v);
        check(v, 8'h00);
        $display("test registers done");
        // dead zone edge: goal plus zone holds, one more dB lowers gain
        for (z = 0; z < 4; z++) begin
            rst(2);
            wr(ADDR_TIMING, {z[1:0], 6'h00});
            wr(ADDR_THRESHOLDS, 8'h48);
            smp(8'h21 + (8'h01 << z));
            check({5'h00, g1}, 8'h07);
            smp(8'h22 + (8'h01 << z));
            check({5'h00, g1}, 8'h06);
            // low side: goal minus zone holds after the wait, one more dB raises gain again
            t = (z == 0) ? 1 : 1 << (z - 1);
            repeat (9) smp(8'h24 - t[7:0]);
            check({5'h00, g1}, 8'h06);
            smp(8'h23 - t[7:0]);
            check({5'h00, g1}, 8'h07);
        end
        $display("test dead zone done");
        // settle wait per code, alternating stage priority
        for (z = 0; z < 4; z++) begin
            rst(2);
            wr(ADDR_TIMING, {2'h0, z[1:0], 4'h0});
            wr(ADDR_THRESHOLDS, {1'b0, z[0], 6'h08});
            smp(8'hC8);
            check({5'h00, z[0] ? g1 : g2}, 8'h06);
            check({5'h00, z[0] ? g2 : g1}, 8'h07);
            check({7'h00, step}, 8'h01);
            repeat (8 * (z + 1)) smp(8'hC8);
            check({5'h00, z[0] ? g1 : g2}, 8'h06);
            check({7'h00, step}, 8'h00);
            smp(8'hC8);
            check({5'h00, z[0] ? g1 : g2}, 8'h05);
        end
        // one stage runs to minimum before the other moves
        for (z = 0; z < 2; z++) begin
            rst(2);
            wr(ADDR_TIMING, 8'h00);
            wr(ADDR_THRESHOLDS, {1'b0, z[0], 6'h08});
            repeat (64) smp(8'hC8);
            check({5'h00, z[0] ? g1 : g2}, 8'h00);
            check({5'h00, z[0] ? g2 : g1}, 8'h06);
        end
        $display("test gain stepping done");
        // every absolute code at its level and one dB below
        rst(2);
        wr(ADDR_TIMING, 8'h00);
        for (z = 0; z < 16; z++) begin
            t = (z < 8) ? 33 + z : 17 + z;
            wr(ADDR_THRESHOLDS, {4'h4, z[3:0]});
            smp(t[7:0]);
            check({7'h00, cs}, {7'h00, z != 8});
            smp(t[7:0] - 8'h01);
            check({7'h00, cs}, 8'h00);
        end
        $display("test absolute level done");
        // every relative code: one dB short, then the full rise
        for (z = 0; z < 4; z++) begin
            t = (z == 0) ? 20 : 2 + 4 * z;
            wr(ADDR_THRESHOLDS, {2'h1, z[1:0], 4'h8});
            smp(8'h32);
            smp(8'h32);
            smp(8'h31 + t[7:0]);
            check({7'h00, cs}, 8'h00);
            smp(8'h32);
            smp(8'h32 + t[7:0]);
            check({7'h00, cs}, {7'h00, z != 0});
        end
        // sense is high here; switching both detections off drops it
        wr(ADDR_THRESHOLDS, 8'h48);
        tick();
        check({7'h00, cs}, 8'h00);
        $display("test relative step done");
        stop_test();
    end
endmodule : test_agccs_core

`default_nettype wire
